// >>> cns_node_config.sv
// Overview of operation
// - Four read/write scratch words, count reads four
// - PDO cycle period read-only, 16-bit milliseconds
// - Cycle period mirrors the PDO1 event timer entry
// - Correct key saves parameters then resets device
// - 64-bit read-only fine position, 16+31 bits
// - Fine position ignores total range settings
// - Fine position scaled by per-revolution resolution
// - 32-bit multi-turn variant drops preset and scaling
// - Effective node identifier is stored byte plus one
// - One-byte code selects bit rate 20..1000
// - Writing 01h switches the bus terminator on
// - Detection listens silently, then boot-up and pre-operational or operational
// - Invalid frames retried until timeout expires
// - Timeout falls back to last known rate
// - Detected rate written back into rate code
// - Detection enable byte, 0 off, 1 on
// - Timeout in milliseconds, zero waits forever
// - Only table rates accepted by detection
// - Red and green indicators flicker during detection
// - Auto-start flag selects operational or pre-operational
module cns_node_config #(
  parameter int unsigned MS_CYCLES = cns_pkg::MS_CYCLES, // Cycles per millisecond
  parameter bit          MT32      = 1'b0                // 32-bit multi-turn variant
) (
  input  wire logic              mclk,           // 125 MHz clock
  input  wire logic              rst,            // Async reset, active high
  input  wire logic              nmt_reset,      // NMT reset pulse
  input  wire cns_pkg::cns_req_s req,            // Object access request
  output cns_pkg::cns_rsp_s      rsp,            // Object access answer
  input  wire logic [15:0]       pdo_event_ms,   // PDO1 event timer entry
  input  wire logic [15:0]       single_turn,    // Raw single-turn position
  input  wire logic [31:0]       multi_turn,     // Raw multi-turn count
  input  wire logic [31:0]       steps_per_rev,  // Resolution per revolution
  input  wire logic              frame_valid,    // Valid frame seen, pulse
  input  wire logic              frame_invalid,  // Invalid frame seen, pulse
  input  wire logic [2:0]        frame_rate,     // Rate code of valid frame
  input  wire logic              nvm_done,       // Non-volatile store finished
  output logic                   nvm_save,       // Store parameters, level
  output logic                   reset_req,      // Device reset, pulse
  output logic [7:0]             node_id,        // Effective node identifier
  output logic [2:0]             rate_sel,       // Active bit-rate code
  output logic                   listen_only,    // No transmission
  output logic                   bootup_tx,      // Send boot-up, pulse
  output logic                   go_preop,       // Enter pre-operational, pulse
  output logic                   go_op,          // Enter operational, pulse
  output logic                   term_on,        // Bus terminator enable
  output logic                   preset_allowed, // Preset and scaling possible
  output logic                   led_red,        // Red indicator
  output logic                   led_green       // Green indicator
);

  // Object hit test, used by both read and write decode
  function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub,
                               input logic [15:0] want_idx, input logic [7:0] want_sub);
    hit = (idx == want_idx) && (sub == want_sub);
  endfunction

  // Stored object values
  logic [31:0]         scratch_q [cns_pkg::SCRATCH_WORDS];
  logic [7:0]          node_q;
  logic [7:0]          rate_q;
  logic [7:0]          term_q;
  logic [7:0]          det_en_q;
  logic [31:0]         timeout_q;
  logic                auto_op_q;
  // Save, start-up and timing state
  logic                saving_q;
  cns_pkg::cns_state_e state_q;
  logic [31:0]         ms_div_q;
  logic [31:0]         ms_cnt_q;
  logic [7:0]          flick_q;
  logic                flick_ph_q;
  // Decode and timing results
  logic [63:0]         fine_pos;
  logic                wr_ok;
  logic                rd_ok;
  logic [63:0]         rd_data;
  logic                ms_tick;
  logic                restart;
  logic                rate_learn;
  logic                timed_out;

  // Either restart source reruns start-up from the stored settings
  assign restart    = nmt_reset || reset_req;
  assign ms_tick    = (ms_div_q == MS_CYCLES - 1);
  // Zero timeout never expires
  assign timed_out  = (timeout_q != 32'h0) && (ms_cnt_q >= timeout_q);
  // Codes beyond the table are not a rate this node can run
  assign rate_learn = (state_q == cns_pkg::ST_DETECT) && frame_valid
                      && ({5'h0, frame_rate} <= cns_pkg::RATE_MAX);

  // Fine position: scaled unless the 32-bit multi-turn variant
  always_comb begin
    logic [63:0] turns;
    logic [63:0] frac;
    turns = 64'(multi_turn[cns_pkg::MT_BITS-1:0]) * 64'(steps_per_rev);
    frac  = (64'(single_turn) * 64'(steps_per_rev)) >> cns_pkg::ST_BITS;
    if (MT32) begin
      fine_pos = {multi_turn, single_turn, 16'h0000};
    end else begin
      fine_pos = turns + frac;
    end
  end

  // Preset and scaling live elsewhere; this only grants them
  assign preset_allowed = !MT32;

  // Write decode; writes to read-only entries are refused
  always_comb begin
    wr_ok = 1'b0;
    if (req.wr) begin
      for (int i = 0; i < cns_pkg::SCRATCH_WORDS; i++) begin
        if (hit(req.index, req.sub, cns_pkg::IDX_SCRATCH, 8'(i + 1))) begin
          wr_ok = 1'b1;
        end
      end
      if (hit(req.index, req.sub, cns_pkg::IDX_SAVE, cns_pkg::SUB_COUNT)) begin
        wr_ok = (req.data == cns_pkg::SAVE_KEY);
      end
      // Byte entries take data[7:0], the auto-start flag data[0]; upper bits are dropped
      if (hit(req.index, req.sub, cns_pkg::IDX_NODE, cns_pkg::SUB_COUNT)
          || hit(req.index, req.sub, cns_pkg::IDX_RATE, cns_pkg::SUB_COUNT)
          || hit(req.index, req.sub, cns_pkg::IDX_TERM, cns_pkg::SUB_COUNT)
          || hit(req.index, req.sub, cns_pkg::IDX_AUTO_OP, cns_pkg::SUB_COUNT)
          || hit(req.index, req.sub, cns_pkg::IDX_DETECT, cns_pkg::SUB_TIMEOUT)) begin
        wr_ok = 1'b1;
      end
      // Only 0h and 1h mean anything for the enable byte
      if (hit(req.index, req.sub, cns_pkg::IDX_DETECT, cns_pkg::SUB_ENABLE)) begin
        wr_ok = (req.data[7:0] <= 8'h01);
      end
    end
  end

  // Read decode
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 64'h0;
    if (req.index == cns_pkg::IDX_SCRATCH) begin
      if (req.sub == cns_pkg::SUB_COUNT) begin
        rd_data = 64'(cns_pkg::SCRATCH_COUNT);
      end else if (req.sub <= cns_pkg::SCRATCH_COUNT) begin
        rd_data = 64'(scratch_q[2'(req.sub - 8'h01)]);
      end else begin
        rd_ok = 1'b0;
      end
    end else if (hit(req.index, req.sub, cns_pkg::IDX_CYCLE, cns_pkg::SUB_COUNT)) begin
      rd_data = 64'(pdo_event_ms);
    end else if (hit(req.index, req.sub, cns_pkg::IDX_FINE_POS, cns_pkg::SUB_COUNT)) begin
      rd_data = fine_pos;
    end else if (hit(req.index, req.sub, cns_pkg::IDX_NODE, cns_pkg::SUB_COUNT)) begin
      rd_data = 64'(node_q);
    end else if (hit(req.index, req.sub, cns_pkg::IDX_RATE, cns_pkg::SUB_COUNT)) begin
      rd_data = 64'(rate_q);
    end else if (hit(req.index, req.sub, cns_pkg::IDX_TERM, cns_pkg::SUB_COUNT)) begin
      rd_data = 64'(term_q);
    end else if (req.index == cns_pkg::IDX_DETECT) begin
      // Count, enable byte, then timeout
      unique case (req.sub)
        cns_pkg::SUB_COUNT:   rd_data = 64'(cns_pkg::DETECT_COUNT);
        cns_pkg::SUB_ENABLE:  rd_data = 64'(det_en_q);
        cns_pkg::SUB_TIMEOUT: rd_data = 64'(timeout_q);
        default:              rd_ok   = 1'b0;
      endcase
    end else if (hit(req.index, req.sub, cns_pkg::IDX_AUTO_OP, cns_pkg::SUB_COUNT)) begin
      rd_data = 64'(auto_op_q);
    end else begin
      rd_ok = 1'b0; // Save entry is write-only, unknown objects abort
    end
  end

  // Answer register, one cycle after the request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp.ack  <= req.wr || req.rd;
      // Write wins when both strobes are up
      rsp.err  <= (req.wr && !wr_ok) || (req.rd && !req.wr && !rd_ok);
      rsp.data <= (req.rd && !req.wr && rd_ok) ? rd_data : 64'h0;
    end
  end

  // Scratch storage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < cns_pkg::SCRATCH_WORDS; i++) begin
        scratch_q[i] <= cns_pkg::SCRATCH_RESET;
      end
    end else if (wr_ok && req.index == cns_pkg::IDX_SCRATCH) begin
      scratch_q[2'(req.sub - 8'h01)] <= req.data;
    end
  end

  // Configuration entries; node, rate and detection enable act at the next start-up, timeout and auto-start flag are read live, the terminator at once
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      node_q    <= cns_pkg::NODE_RESET;
      term_q    <= cns_pkg::TERM_RESET;
      det_en_q  <= cns_pkg::DETECT_EN_RESET;
      timeout_q <= cns_pkg::TIMEOUT_RESET;
      auto_op_q <= cns_pkg::AUTO_OP_RESET;
    end else if (wr_ok && req.sub == cns_pkg::SUB_COUNT) begin
      if (req.index == cns_pkg::IDX_NODE) begin
        node_q <= req.data[7:0];
      end
      if (req.index == cns_pkg::IDX_TERM) begin
        term_q <= req.data[7:0];
      end
      if (req.index == cns_pkg::IDX_AUTO_OP) begin
        auto_op_q <= req.data[0];
      end
    end else if (wr_ok && req.index == cns_pkg::IDX_DETECT) begin
      if (req.sub == cns_pkg::SUB_ENABLE) begin
        det_en_q <= req.data[7:0];
      end else begin
        timeout_q <= req.data;
      end
    end
  end

  // Rate code: learnt rate wins over a software write in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rate_q <= cns_pkg::RATE_RESET;
    end else if (rate_learn) begin
      rate_q <= {5'h0, frame_rate};
    end else if (wr_ok && hit(req.index, req.sub, cns_pkg::IDX_RATE, cns_pkg::SUB_COUNT)) begin
      // Any byte is kept; start-up runs out-of-table codes at 125 kbit/s
      rate_q <= req.data[7:0];
    end
  end

  // Terminator acts on 01h only; it is lost with power anyway
  assign term_on = (term_q == cns_pkg::TERM_ON);

  // Save with reset: store, wait for the memory, then reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      saving_q  <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      reset_req <= saving_q && nvm_done;
      // Set wins, so a key landing as a store ends is not lost
      if (wr_ok && req.index == cns_pkg::IDX_SAVE) begin
        saving_q <= 1'b1;
      end else if (nvm_done) begin
        saving_q <= 1'b0;
      end
    end
  end

  // Level, held until the store answers
  assign nvm_save = saving_q;

  // Millisecond base and elapsed time since start-up
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ms_div_q <= 32'h0;
      ms_cnt_q <= 32'h0;
    end else if (restart || state_q == cns_pkg::ST_LATCH) begin
      ms_div_q <= 32'h0;
      ms_cnt_q <= 32'h0;
    end else begin
      ms_div_q <= ms_tick ? 32'h0 : ms_div_q + 32'h1;
      // Count freezes once expired, so with a nonzero timeout it never wraps back
      if (ms_tick && !timed_out) begin
        ms_cnt_q <= ms_cnt_q + 32'h1;
      end
    end
  end

  // Start-up sequence; an NMT reset restarts it from the stored settings
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q  <= cns_pkg::ST_LATCH;
      node_id  <= 8'h0;
      rate_sel <= cns_pkg::RATE_125;
    end else if (restart) begin
      state_q <= cns_pkg::ST_LATCH;
    end else begin
      unique case (state_q)
        cns_pkg::ST_LATCH: begin
          // Stored settings are copied here and nowhere else
          node_id <= node_q + 8'h01;
          // Never-configured code falls back to 125 kbit/s
          rate_sel <= (rate_q <= cns_pkg::RATE_MAX) ? rate_q[2:0]
                                                     : cns_pkg::RATE_125;
          state_q <= (det_en_q == 8'h01) ? cns_pkg::ST_DETECT
                                         : cns_pkg::ST_BOOT;
        end
        cns_pkg::ST_DETECT: begin
          if (rate_learn) begin
            rate_sel <= frame_rate;
            state_q  <= cns_pkg::ST_BOOT;
          end else if (timed_out) begin
            state_q <= cns_pkg::ST_BOOT;
          end else if (frame_invalid) begin
            // A bad frame only restarts the hunt; the timeout runs on
            state_q <= cns_pkg::ST_DETECT;
          end
        end
        // One cycle: boot-up frame and the state choice
        cns_pkg::ST_BOOT: begin
          state_q <= cns_pkg::ST_RUN;
        end
        // Only a restart leaves the running state
        cns_pkg::ST_RUN: begin
          state_q <= cns_pkg::ST_RUN;
        end
      endcase
    end
  end

  assign listen_only = (state_q == cns_pkg::ST_DETECT) || (state_q == cns_pkg::ST_LATCH);
  assign bootup_tx   = (state_q == cns_pkg::ST_BOOT);
  assign go_op       = (state_q == cns_pkg::ST_BOOT) && auto_op_q;
  assign go_preop    = (state_q == cns_pkg::ST_BOOT) && !auto_op_q;

  // Alternate flicker while the rate search runs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flick_q    <= 8'h0;
      flick_ph_q <= 1'b0;
    end else if (state_q == cns_pkg::ST_LATCH) begin
      // Each search starts with a full green phase
      flick_q    <= 8'h0;
      flick_ph_q <= 1'b0;
    end else if (ms_tick) begin
      if (flick_q == 8'(cns_pkg::FLICKER_MS - 1)) begin
        flick_q    <= 8'h0;
        flick_ph_q <= !flick_ph_q;
      end else begin
        flick_q <= flick_q + 8'h01;
      end
    end
  end

  // Indicators are left dark outside the search; status display lives elsewhere
  assign led_red   = (state_q == cns_pkg::ST_DETECT) && flick_ph_q;
  assign led_green = (state_q == cns_pkg::ST_DETECT) && !flick_ph_q;

endmodule

// >>> cns_pkg.sv
package cns_pkg;

  // Object dictionary indices
  localparam logic [15:0] IDX_SCRATCH  = 16'h2160;
  localparam logic [15:0] IDX_CYCLE    = 16'h2200;
  localparam logic [15:0] IDX_SAVE     = 16'h2300;
  localparam logic [15:0] IDX_FINE_POS = 16'h2600;
  localparam logic [15:0] IDX_NODE     = 16'h3000;
  localparam logic [15:0] IDX_RATE     = 16'h3001;
  localparam logic [15:0] IDX_TERM     = 16'h3002;
  localparam logic [15:0] IDX_DETECT   = 16'h3003;
  localparam logic [15:0] IDX_AUTO_OP  = 16'h3005;

  // Sub-indices
  localparam logic [7:0] SUB_COUNT   = 8'h00;
  localparam logic [7:0] SUB_ENABLE  = 8'h01;
  localparam logic [7:0] SUB_TIMEOUT = 8'h02;

  // Entry counts reported by sub-index 0
  localparam int unsigned SCRATCH_WORDS   = 4;
  localparam logic [7:0]  SCRATCH_COUNT   = 8'h04;
  localparam logic [7:0]  DETECT_COUNT    = 8'h02;

  // Reset values, save key and terminator code
  localparam logic [31:0] SAVE_KEY        = 32'h55aaaa55;
  localparam logic [7:0]  NODE_RESET      = 8'h1f;
  localparam logic [7:0]  RATE_RESET      = 8'h1f;
  localparam logic [7:0]  TERM_RESET      = 8'h00;
  localparam logic [7:0]  TERM_ON         = 8'h01;
  localparam logic [7:0]  DETECT_EN_RESET = 8'h01;
  localparam logic [31:0] TIMEOUT_RESET   = 32'h0002bf20;
  localparam logic        AUTO_OP_RESET   = 1'b0;
  localparam logic [31:0] SCRATCH_RESET   = 32'h00000000;

  // Bit-rate codes (kbit/s in name)
  localparam logic [2:0] RATE_20   = 3'h0;
  localparam logic [2:0] RATE_50   = 3'h1;
  localparam logic [2:0] RATE_100  = 3'h2;
  localparam logic [2:0] RATE_125  = 3'h3;
  localparam logic [2:0] RATE_250  = 3'h4;
  localparam logic [2:0] RATE_500  = 3'h5;
  localparam logic [2:0] RATE_800  = 3'h6;
  localparam logic [2:0] RATE_1000 = 3'h7;
  localparam logic [7:0] RATE_MAX  = 8'h07;

  // Position field widths
  localparam int unsigned ST_BITS = 16;
  localparam int unsigned MT_BITS = 31;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned FLICKER_MS    = 50;

  // Object access request from the SDO server
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } cns_req_s;

  // Object access answer, one cycle after the request
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [63:0] data;
  } cns_rsp_s;

  typedef enum logic [1:0] {
    ST_LATCH  = 2'b00,
    ST_DETECT = 2'b01,
    ST_BOOT   = 2'b11,
    ST_RUN    = 2'b10
  } cns_state_e;

endpackage

// >>> cns_node_properties.sv
module cns_node_properties #(
  parameter bit MT32 = 1'b0 // Variant in use
) (
  input wire logic              mclk,           // Clock
  input wire logic              rst,            // Reset
  input wire cns_pkg::cns_req_s req,            // Request
  input wire cns_pkg::cns_rsp_s rsp,            // Answer
  input wire logic              frame_valid,    // Good frame
  input wire logic [2:0]        frame_rate,     // Its rate
  input wire logic              nvm_done,       // Store done
  input wire logic              nvm_save,       // Store busy
  input wire logic              reset_req,      // Restart
  input wire logic [7:0]        node_id,        // Node id
  input wire logic [2:0]        rate_sel,       // Rate
  input wire logic              listen_only,    // Silent
  input wire logic              bootup_tx,      // Boot-up
  input wire logic              go_preop,       // Pre-op
  input wire logic              go_op,          // Op
  input wire logic              term_on,        // Terminator
  input wire logic              preset_allowed, // Preset ok
  input wire logic              led_red,        // Red
  input wire logic              led_green       // Green
);
  timeunit 1ns;
  timeprecision 100ps;
  logic key_wr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Save entry write, whatever the key
  assign key_wr = req.wr && req.index == cns_pkg::IDX_SAVE && req.sub == 8'h00;

  // Steps of the start-up and save sequences
  sequence hit_s;
    listen_only && frame_valid;
  endsequence
  sequence save_end_s;
    nvm_save && nvm_done;
  endsequence
  sequence run_two_s;
    !listen_only ##1 !listen_only;
  endsequence

  req_ack_a: assert property ((req.wr || req.rd) |=> rsp.ack)
    else $error("request not answered");
  key_save_a: assert property ((key_wr && req.data == cns_pkg::SAVE_KEY) |=> nvm_save)
    else $error("key did not start store");
  bad_key_a: assert property ((key_wr && req.data != cns_pkg::SAVE_KEY && !nvm_save)
    |=> rsp.err && !nvm_save) else $error("wrong key accepted");
  save_reset_a: assert property (save_end_s |=> reset_req && !nvm_save)
    else $error("no restart after store");
  term_follow_a: assert property ((req.wr && req.sub == 8'h00
    && req.index == cns_pkg::IDX_TERM) |=> term_on == ($past(req.data[7:0]) == cns_pkg::TERM_ON))
    else $error("terminator wrong");
  silent_listen_a: assert property (listen_only |-> !(bootup_tx || go_preop || go_op))
    else $error("sent while listening");
  boot_once_a: assert property (bootup_tx |=> !bootup_tx)
    else $error("boot-up repeated");
  boot_mode_a: assert property (bootup_tx |-> go_preop != go_op)
    else $error("boot state choice wrong");
  rate_learn_a: assert property (hit_s |=> bootup_tx && rate_sel == $past(frame_rate))
    else $error("found rate not taken");
  setting_hold_a: assert property (run_two_s |-> $stable(node_id) && $stable(rate_sel))
    else $error("settings changed while running");
  led_quiet_a: assert property (!listen_only |-> !led_red && !led_green)
    else $error("indicator lit outside search");
  led_alt_a: assert property (led_red |-> !led_green)
    else $error("both indicators lit");
  variant_a: assert property (preset_allowed != MT32)
    else $error("preset permission wrong");
endmodule

bind cns_node_config cns_node_properties #(.MT32(MT32)) cns_node_properties_i (
  .mclk(mclk), .rst(rst), .req(req), .rsp(rsp), .frame_valid(frame_valid),
  .frame_rate(frame_rate), .nvm_done(nvm_done), .nvm_save(nvm_save), .reset_req(reset_req),
  .node_id(node_id), .rate_sel(rate_sel), .listen_only(listen_only), .bootup_tx(bootup_tx),
  .go_preop(go_preop), .go_op(go_op), .term_on(term_on), .preset_allowed(preset_allowed),
  .led_red(led_red), .led_green(led_green)
);

// >>> cns_nvm_model.sv
module cns_nvm_model (
  input  wire logic       mclk,     // Clock
  input  wire logic       rst,      // Async reset
  input  wire logic [3:0] delay,    // Store time in cycles
  input  wire logic       nvm_save, // Store request
  output logic            nvm_done  // Store finished
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_q;
  // Store timer; restarts whenever the request drops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else if (!nvm_save) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != delay) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // Done stays up until the request drops, as a slow store would hold it
  assign nvm_done = nvm_save && (cnt_q == delay);
endmodule

// >>> cns_node_config_test.sv
module cns_node_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic              mclk = 1'b0, rst = 1'b1, nmt_reset = 1'b0;
  logic              frame_valid = 1'b0, frame_invalid = 1'b0, nvm_done, nvm_save;
  logic              reset_req, listen_only, bootup_tx, go_preop, go_op;
  logic              term_on, preset_allowed, led_red, led_green;
  logic [2:0]        frame_rate = 3'h0, rate_sel;
  logic [7:0]        node_id;
  logic [15:0]       pdo_event_ms = 16'h01f4, single_turn = 16'h1234;
  logic [31:0]       multi_turn = 32'h80000005, steps_per_rev = 32'h00010000;
  cns_pkg::cns_req_s req = '0;
  cns_pkg::cns_rsp_s rsp;
  int                err_count = 0, total_checks = 0, n;
  // Defaults after reset: index, sub, expected value
  logic [15:0] di_t [9] = '{16'h2160, 16'h2200, 16'h3000, 16'h3001, 16'h3002, 16'h3003,
                            16'h3003, 16'h3003, 16'h3005};
  logic [7:0]  ds_t [9] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1, 8'h2, 8'h0};
  logic [63:0] dx_t [9] = '{64'h4, 64'h1f4, 64'h1f, 64'h1f, 64'h0, 64'h2, 64'h1, 64'h2bf20,
                            64'h0};
  // Refused accesses: write flag, index, sub
  logic        ew_t [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [15:0] ei_t [8] = '{16'h2160, 16'h2200, 16'h2600, 16'h2300, 16'h3003, 16'h3003,
                            16'h2170, 16'h2160};
  logic [7:0]  es_t [8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1, 8'h0, 8'h5};

  cns_node_config #(.MS_CYCLES(10)) cns_node_config_i (
    .mclk(mclk), .rst(rst), .nmt_reset(nmt_reset), .req(req), .rsp(rsp),
    .pdo_event_ms(pdo_event_ms), .single_turn(single_turn), .multi_turn(multi_turn),
    .steps_per_rev(steps_per_rev), .frame_valid(frame_valid),
    .frame_invalid(frame_invalid), .frame_rate(frame_rate), .nvm_done(nvm_done),
    .nvm_save(nvm_save), .reset_req(reset_req), .node_id(node_id), .rate_sel(rate_sel),
    .listen_only(listen_only), .bootup_tx(bootup_tx), .go_preop(go_preop), .go_op(go_op),
    .term_on(term_on), .preset_allowed(preset_allowed), .led_red(led_red),
    .led_green(led_green)
  );
  // Slow store, so the save level is seen to stand
  cns_nvm_model cns_nvm_model_i (
    .mclk(mclk), .rst(rst), .delay(4'h5), .nvm_save(nvm_save), .nvm_done(nvm_done)
  );

  always #4 mclk = ~mclk;

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One object access; the answer stands only in the cycle after the request
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] d, input logic e, input logic [63:0] x);
    req = '{wr: w, rd: !w, index: i, sub: s, data: d};
    tick();
    check($sformatf("answer %h.%h", i, s), 64'({rsp.ack, rsp.err}), 64'({1'b1, e}));
    if (!w && !e) check($sformatf("data %h.%h", i, s), rsp.data, x);
    req = '0;
    tick();
  endtask
  // Single-cycle frame report from the controller
  task automatic frame(input logic v, input logic [2:0] r);
    frame_valid = v;
    frame_invalid = !v;
    frame_rate = r;
    tick();
    frame_valid = 1'b0;
    frame_invalid = 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cut a hang short; the whole run needs well under a thousand cycles
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    tick();
    tick();
    check("node_id", 64'(node_id), 64'h20);
    check("rate_sel", 64'(rate_sel), 64'h3);
    for (int k = 0; k < 9; k++) begin
      acc(1'b0, di_t[k], ds_t[k], 32'h0, 1'b0, dx_t[k]);
    end
    $display("defaults done");
    for (int k = 1; k < 5; k++) begin
      acc(1'b1, 16'h2160, 8'(k), 32'hc0de0000 | k, 1'b0, 64'h0);
    end
    for (int k = 1; k < 5; k++) begin
      acc(1'b0, 16'h2160, 8'(k), 32'h0, 1'b0, 64'(32'hc0de0000 | k));
    end
    for (int k = 0; k < 8; k++) begin
      acc(ew_t[k], ei_t[k], es_t[k], 32'h2, 1'b1, 64'h0);
    end
    $display("storage and refusals done");
    frame(1'b0, 3'h0);
    check("listen_only", 64'(listen_only), 64'h1);
    check("leds", 64'({led_red, led_green}), 64'h1);
    for (n = 0; n < 600 && led_red !== 1'b1; n++) tick();
    check("leds", 64'({led_red, led_green}), 64'h2);
    frame(1'b1, 3'h5);
    check("boot", 64'({bootup_tx, go_preop, go_op, rate_sel}), 64'h35);
    tick();
    check("listen_only", 64'(listen_only), 64'h0);
    acc(1'b0, 16'h3001, 8'h0, 32'h0, 1'b0, 64'h5);
    $display("rate search done");
    acc(1'b0, 16'h2600, 8'h0, 32'h0, 1'b0, 64'h51234);
    steps_per_rev = 32'h00020000;
    acc(1'b0, 16'h2600, 8'h0, 32'h0, 1'b0, 64'ha2468);
    check("preset_allowed", 64'(preset_allowed), 64'h1);
    $display("fine position done");
    acc(1'b1, 16'h3000, 8'h0, 32'h5, 1'b0, 64'h0);
    acc(1'b1, 16'h3002, 8'h0, 32'h1, 1'b0, 64'h0);
    check("node_id", 64'(node_id), 64'h20);
    check("term_on", 64'(term_on), 64'h1);
    acc(1'b1, 16'h3003, 8'h2, 32'h3, 1'b0, 64'h0);
    acc(1'b1, 16'h3005, 8'h0, 32'h1, 1'b0, 64'h0);
    acc(1'b1, 16'h2300, 8'h0, 32'h55aaaa54, 1'b1, 64'h0);
    check("nvm_save", 64'(nvm_save), 64'h0);
    acc(1'b1, 16'h2300, 8'h0, 32'h55aaaa55, 1'b0, 64'h0);
    check("nvm_save", 64'(nvm_save), 64'h1);
    for (n = 0; n < 20 && reset_req !== 1'b1; n++) tick();
    check("reset_req", 64'(reset_req), 64'h1);
    for (n = 0; n < 200 && bootup_tx !== 1'b1; n++) tick();
    check("timeout", 64'(n >= 25 && n <= 40), 64'h1);
    check("boot", 64'({bootup_tx, go_preop, go_op, rate_sel}), 64'h2d);
    check("node_id", 64'(node_id), 64'h6);
    $display("save and restart done");
    acc(1'b1, 16'h3003, 8'h1, 32'h0, 1'b0, 64'h0);
    acc(1'b1, 16'h3005, 8'h0, 32'h0, 1'b0, 64'h0);
    acc(1'b1, 16'h3001, 8'h0, 32'h2, 1'b0, 64'h0);
    acc(1'b1, 16'h3002, 8'h0, 32'h2, 1'b0, 64'h0);
    check("term_on", 64'(term_on), 64'h0);
    check("rate_sel", 64'(rate_sel), 64'h5);
    nmt_reset = 1'b1;
    tick();
    nmt_reset = 1'b0;
    check("listen_only", 64'(listen_only), 64'h1);
    tick();
    check("boot", 64'({bootup_tx, go_preop, go_op, rate_sel}), 64'h32);
    $display("detection off done");
    give_verdict();
  end
endmodule
